// ===== logic/adcsb_ctrl.sv
// Control of reference, scanning, alternate sampling and result buffer.
// Assumes an APB master on pclk and a converter core giving done pulses.
//
// Summary of operation
// RL1: Reference field selects rails or external pins
// RL2: Unimplemented bits read zero, ignore writes
// RL3: Scan bit steps positive input through inputs
// RL4: Fill flag shows half being filled
// RL5: Flag one for upper half, zero lower
// RL6: Interrupt after programmed count of sequences; code interrupts after that count plus one
// RL7: Split mode uses two eight-word halves
// RL8: Otherwise one eight-word buffer from start
// RL9: Alternate mode: first selector, then second, alternating
// RL10: Without alternate, first selector always
// RL11: Count completion swaps half, restarts counter
// RL12: Software keeps reserved bit twelve zero
`timescale 1ns/10ps
module adcsb_ctrl
    import adcsb_pkg::*;
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter core
    input wire logic conv_req,
    input wire logic conv_done,
    input wire logic seq_end,
    output adcsb_cmd_s cmd,
    // Interrupt
    output logic irq
);

////////////////////////////////////////////////////////////////////////
    logic [15:0] ctrl;
    logic fill_half;
    logic [3:0] seq_cnt;
    logic [2:0] word_cnt;
    logic alt_phase;
    logic [ADCSB_IRQ_W-1:0] stat;
    logic [ADCSB_IRQ_W-1:0] mask;
    logic [ADCSB_IRQ_W-1:0] next_stat;
    logic [ADCSB_IRQ_W-1:0] next_mask;
    logic [31:0] next_prdata;
    adcsb_state_e state;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic seq_evt;
    logic cnt_full;
    logic [3:0] spi;
    logic split;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign hit = paddr == ADCSB_CTRL_OFF || paddr == ADCSB_STAT_OFF
        || paddr == ADCSB_MASK_OFF || paddr == ADCSB_SMP_OFF;
    assign spi = ctrl[ADCSB_SPI_HI:ADCSB_SPI_LO];
    assign split = ctrl[ADCSB_SPLIT_BIT];
    assign seq_evt = (state == ADCSB_STORE) && seq_end;
    assign cnt_full = seq_cnt == spi; // [RL6]

////////////////////////////////////////////////////////////////////////
    // Control register; only writable bits stored, so the rest read zero except the fill flag at bit 7
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= ADCSB_CTRL_RST;
        else if (wr_en && paddr == ADCSB_CTRL_OFF)
            ctrl <= pwdata[15:0] & (ADCSB_CTRL_WMASK | ADCSB_CTRL_WMASK_SEQUENCES_PER_IRQ); // [RL2]
    end

    // Reserved bit 12 dropped on write; software keeps it zero [RL12]

    // Sequence counter; counts completed sequences up to the limit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seq_cnt <= 4'h0;
        else if (seq_evt && cnt_full)
            seq_cnt <= 4'h0; // [RL6] [RL11]
        else if (seq_evt)
            seq_cnt <= seq_cnt + 4'h1; // [RL6]
    end

    // Fill half; single mode pins it low so a later split starts low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fill_half <= 1'b0;
        else if (!split)
            fill_half <= 1'b0; // [RL8]
        else if (seq_evt && cnt_full)
            fill_half <= !fill_half; // [RL4] [RL5] [RL11]
    end

    // Write pointer inside the active half or whole buffer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            word_cnt <= 3'h0;
        else if (seq_evt && cnt_full)
            word_cnt <= 3'h0; // [RL8]
        else if (state == ADCSB_STORE && word_cnt != ADCSB_LAST_IN_HALF)
            word_cnt <= word_cnt + 3'h1;
    end

    // Alternation between first and second selector
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alt_phase <= 1'b0;
        else if (!ctrl[ADCSB_ALT_BIT])
            alt_phase <= 1'b0; // [RL10]
        else if (state == ADCSB_STORE)
            alt_phase <= !alt_phase; // [RL9]
    end

    // Sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= ADCSB_IDLE;
        else
            case (state)
                ADCSB_IDLE: if (conv_req) state <= ADCSB_CONV;
                ADCSB_CONV: if (conv_done) state <= ADCSB_STORE;
                ADCSB_STORE: state <= ADCSB_IDLE;
                default: state <= ADCSB_IDLE;
            endcase
    end

    // Command register toward the core
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmd <= '0;
        else
        begin
            cmd.start <= (state == ADCSB_IDLE) && conv_req;
            cmd.second_sel <= ctrl[ADCSB_ALT_BIT] && alt_phase; // [RL9] [RL10]
            cmd.scan_step <= ctrl[ADCSB_SCAN_BIT] && (state == ADCSB_STORE)
                && !alt_phase; // [RL3]
            // Split mode: upper half offset when fill flag set [RL7]
            if (split)
                cmd.addr <= (fill_half ? ADCSB_HALF_BASE : 4'h0) | {1'b0, word_cnt};
            else
                cmd.addr <= {1'b0, word_cnt}; // [RL8]
            cmd.ref_pos_ext <= !ctrl[ADCSB_REF_HI]
                && ctrl[ADCSB_REF_LO]; // [RL1]
            cmd.ref_neg_ext <= !ctrl[ADCSB_REF_HI]
                && ctrl[ADCSB_REF_LO+1]; // [RL1]
        end
    end

////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over write-one-to-clear
    always_comb
    begin
        next_stat = stat;
        if (wr_en && paddr == ADCSB_STAT_OFF)
            next_stat = stat & ~pwdata[ADCSB_IRQ_W-1:0];
        if (seq_evt && cnt_full)
            next_stat[ADCSB_IRQ_SEQ] = 1'b1; // [RL6]
        if (seq_evt && cnt_full && split)
            next_stat[ADCSB_IRQ_SWAP] = 1'b1; // [RL11]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat <= '0;
        else
            stat <= next_stat;
    end

    // Mask next value, so the interrupt follows a mask write at once
    always_comb
    begin
        next_mask = mask;
        if (wr_en && paddr == ADCSB_MASK_OFF)
            next_mask = pwdata[ADCSB_IRQ_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask <= '0;
        else
            mask <= next_mask;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(next_stat & next_mask); // [RL6]
    end

////////////////////////////////////////////////////////////////////////
    // Read data captured in setup, so access phase answers at once
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            ADCSB_CTRL_OFF:
            begin
                next_prdata[15:0] = ctrl;
                next_prdata[ADCSB_FILL_BIT] = fill_half; // [RL4] [RL5]
            end
            ADCSB_STAT_OFF: next_prdata[ADCSB_IRQ_W-1:0] = stat;
            ADCSB_MASK_OFF: next_prdata[ADCSB_IRQ_W-1:0] = mask;
            ADCSB_SMP_OFF: next_prdata[3:0] = seq_cnt;
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end
        else
        begin
            if (rd_en)
                prdata <= next_prdata;
            pslverr <= psel && !penable && !hit;
            pready <= psel && !penable;
        end
    end

////////////////////////////////////////////////////////////////////////
    // Register map
    AST_UNIMP_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        (ctrl & ~(ADCSB_CTRL_WMASK | ADCSB_CTRL_WMASK_SEQUENCES_PER_IRQ)) == 16'h0000)
        else $error("unimplemented control bits set");

    AST_UNIMP_READ: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        rd_en && paddr == ADCSB_CTRL_OFF |=> !prdata[ADCSB_SCAN_BIT+1]
        && prdata[ADCSB_SCAN_BIT-1 -: 2] == 2'h0 && !prdata[ADCSB_FILL_BIT-1])
        else $error("unimplemented bits read nonzero");

    AST_FILL_READ: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
        rd_en && paddr == ADCSB_CTRL_OFF |=> prdata[ADCSB_FILL_BIT] == $past(fill_half))
        else $error("fill flag read wrong");

    // Reference
    AST_REF_TOP: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        ctrl[ADCSB_REF_HI] |=> !cmd.ref_pos_ext && !cmd.ref_neg_ext)
        else $error("external reference with top bit set");

    AST_REF_BOTH: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        !ctrl[ADCSB_REF_HI] && ctrl[ADCSB_REF_LO+1] && ctrl[ADCSB_REF_LO]
        |=> cmd.ref_pos_ext && cmd.ref_neg_ext)
        else $error("external pins not both selected");

    AST_REF_RAILS: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        !ctrl[ADCSB_REF_HI] && !ctrl[ADCSB_REF_LO+1] && !ctrl[ADCSB_REF_LO]
        |=> !cmd.ref_pos_ext && !cmd.ref_neg_ext)
        else $error("rails not selected");

    // Scanning
    AST_SCAN_OFF: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
        !ctrl[ADCSB_SCAN_BIT] |=> !cmd.scan_step)
        else $error("scan step while scanning off");

    AST_SCAN_ON: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
        ctrl[ADCSB_SCAN_BIT] && state == ADCSB_STORE && !alt_phase |=> cmd.scan_step)
        else $error("scan step missing");

    // Buffer halves
    AST_SWAP: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        seq_evt && cnt_full && split |=> fill_half != $past(fill_half))
        else $error("fill half did not swap");

    AST_NO_SWAP: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
        split && !(seq_evt && cnt_full) |=> fill_half == $past(fill_half))
        else $error("fill half swapped early");

    AST_SINGLE: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        !split |=> !fill_half)
        else $error("fill half set in single mode");

    AST_SINGLE_ADDR: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        !split |=> !cmd.addr[3])
        else $error("upper word addressed in single mode");

    AST_SPLIT_ADDR: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
        split && fill_half |=> cmd.addr[3])
        else $error("wrong half addressed");

    AST_LOWER_HALF: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
        split && !fill_half |=> !cmd.addr[3])
        else $error("lower half not addressed");

    AST_SWAP_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        seq_evt && cnt_full && split |=> stat[ADCSB_IRQ_SWAP])
        else $error("half swap not flagged");

    AST_PTR_RESTART: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        seq_evt && cnt_full |=> word_cnt == 3'h0)
        else $error("word pointer not restarted");

    // Interrupt count
    AST_CNT_RESTART: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
        seq_evt && cnt_full |=> seq_cnt == 4'h0)
        else $error("counter not restarted");

    AST_CNT_STEP: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
        seq_evt && !cnt_full |=> seq_cnt == $past(seq_cnt) + 4'h1)
        else $error("counter did not step");

    AST_IRQ_SET: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
        seq_evt && cnt_full |=> stat[ADCSB_IRQ_SEQ])
        else $error("sequence interrupt not flagged");

    AST_NO_EARLY_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
        !(seq_evt && cnt_full) && !stat[ADCSB_IRQ_SEQ] |=> !stat[ADCSB_IRQ_SEQ])
        else $error("sequence interrupt flagged early");

    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
        irq == |(stat & mask))
        else $error("interrupt line disagrees with status");

    // Selector alternation
    AST_NO_ALT: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
        !ctrl[ADCSB_ALT_BIT] ##1 !ctrl[ADCSB_ALT_BIT] |-> !cmd.second_sel)
        else $error("second selector used without alternation");

    AST_ALT_OFF_PHASE: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
        !ctrl[ADCSB_ALT_BIT] |=> !alt_phase)
        else $error("alternation phase kept");

    AST_ALT_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
        ctrl[ADCSB_ALT_BIT] && state == ADCSB_STORE |=> alt_phase != $past(alt_phase))
        else $error("alternation did not toggle");

    AST_ALT_SEL: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
        ctrl[ADCSB_ALT_BIT] && alt_phase |=> cmd.second_sel)
        else $error("second selector not used");
endmodule

// ===== logic/adcsb_pkg.sv
// Package for the converter sequence/buffer control block.
// Assumes an APB master with 32-bit data and word-aligned addresses.
package adcsb_pkg;
    // Register byte offsets
    localparam logic [7:0] ADCSB_CTRL_OFF = 8'h00;
    localparam logic [7:0] ADCSB_STAT_OFF = 8'h04;
    localparam logic [7:0] ADCSB_MASK_OFF = 8'h08;
    localparam logic [7:0] ADCSB_SMP_OFF = 8'h0c;
    // Control register layout
    localparam logic [15:0] ADCSB_CTRL_RST = 16'h0000;
    localparam logic [15:0] ADCSB_CTRL_WMASK = 16'he407;
    localparam logic [15:0] ADCSB_CTRL_WMASK_SEQUENCES_PER_IRQ = 16'h003c;
    localparam int ADCSB_REF_HI = 15;
    localparam int ADCSB_REF_LO = 13;
    localparam int ADCSB_SCAN_BIT = 10;
    localparam int ADCSB_FILL_BIT = 7;
    localparam int ADCSB_SPI_HI = 5;
    localparam int ADCSB_SPI_LO = 2;
    localparam int ADCSB_SPLIT_BIT = 1;
    localparam int ADCSB_ALT_BIT = 0;
    // Interrupt status bits
    localparam int ADCSB_IRQ_SEQ = 0;
    localparam int ADCSB_IRQ_SWAP = 1;
    localparam int ADCSB_IRQ_W = 2;
    // Buffer geometry
    localparam logic [3:0] ADCSB_HALF_BASE = 4'h8;
    localparam logic [2:0] ADCSB_LAST_IN_HALF = 3'h7;
    // Reference choices
    typedef enum logic [1:0]
    {
        ADCSB_REF_RAILS = 2'h0,
        ADCSB_REF_EXT_POS = 2'h1,
        ADCSB_REF_EXT_NEG = 2'h2,
        ADCSB_REF_EXT_BOTH = 2'h3
    } adcsb_ref_e;
    // Sequencer states, gray except the store-to-idle step
    typedef enum logic [1:0]
    {
        ADCSB_IDLE = 2'b00,
        ADCSB_CONV = 2'b01,
        ADCSB_STORE = 2'b11
    } adcsb_state_e;
    // Command toward the converter core
    typedef struct packed
    {
        logic start;
        logic second_sel;
        logic scan_step;
        logic [3:0] addr;
        logic ref_pos_ext;
        logic ref_neg_ext;
    } adcsb_cmd_s;
endpackage

// ===== dv/adcsb_core_model.sv
// Converter core stand-in: requests conversions up to a quota.
// Assumes one sample per sequence and the control block's cmd struct.
`timescale 1ns/10ps
module adcsb_core_model
    import adcsb_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench side
    input var int quota,
    output int starts,
    output int scans,
    output logic [3:0] sel_hist,
    output adcsb_cmd_s last,
    output logic busy,
    // Control block side
    input wire adcsb_cmd_s cmd,
    output logic conv_req,
    output logic conv_done,
    output logic seq_end
);
    logic [1:0] wt;
    assign busy = (wt != 2'h0) || conv_req;
    ////////////////////////////////////////////////////////////////////////////
    // Slow core: three cycles per conversion, no request while busy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {wt, conv_req, conv_done, seq_end, starts, scans, sel_hist, last} <= '0;
        end
        else
        begin
            seq_end <= 1'b1;
            conv_done <= (wt == 2'h1);
            conv_req <= (starts < quota) && (wt == 2'h0) && !cmd.start;
            if (wt != 2'h0)
                wt <= wt - 2'h1;
            if (cmd.start)
            begin
                wt <= 2'h3;
                starts <= starts + 1;
                last <= cmd;
                sel_hist <= {sel_hist[2:0], cmd.second_sel};
            end
            if (cmd.scan_step)
                scans <= scans + 1;
        end
    end
endmodule

// ===== dv/tb_adc_sequence_buffer_control.sv
// Bench: APB register tests with the core model on the far side.
// Assumes zero-wait APB answers and the register map of the package.
`timescale 1ns/10ps
module tb_adc_sequence_buffer_control
    import adcsb_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, conv_req, conv_done, seq_end, irq, busy, e;
    logic [3:0] sel_hist;
    adcsb_cmd_s cmd, last;
    int quota = 0, starts, scans, miscompares = 0, checked = 0, s0, s1;
    always #10 pclk = ~pclk;
    adcsb_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_req(conv_req), .conv_done(conv_done), .seq_end(seq_end),
        .cmd(cmd), .irq(irq));
    adcsb_core_model core (.pclk(pclk), .presetn(presetn), .quota(quota), .starts(starts),
        .scans(scans), .sel_hist(sel_hist), .last(last), .busy(busy), .cmd(cmd),
        .conv_req(conv_req), .conv_done(conv_done), .seq_end(seq_end));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask
    // Called at a rising edge; leaves one idle cycle after each transfer
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(0, a, '0);
        chk("read", x, q);
    endtask
    // Runs n conversions and lets the sequencer settle
    task seqs(input int n);
        s0 = starts;
        quota <= s0 + n;
        repeat (2) @(posedge pclk);
        while (starts != s0 + n || busy)
            @(posedge pclk);
        repeat (4) @(posedge pclk);
    endtask
    task report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(ADCSB_CTRL_OFF, 32'h0);
        rd(ADCSB_STAT_OFF, 32'h0);
        rd(ADCSB_MASK_OFF, 32'h0);
        rd(8'h10, 32'h0);
        chk("slverr", 1, e);
        apb(1, ADCSB_CTRL_OFF, 32'hffffffff);
        rd(ADCSB_CTRL_OFF, 32'h0000e43f);
        $display("registers done");
        // Reference choices; bit 12 kept clear
        for (int v = 0; v < 8; v++)
        begin
            apb(1, ADCSB_CTRL_OFF, v << 13);
            seqs(1);
            chk("ref", {v == 1 || v == 3, v == 2 || v == 3}, {last.ref_pos_ext, last.ref_neg_ext});
        end
        $display("reference done");
        apb(1, ADCSB_MASK_OFF, 32'h1);
        for (int k = 0; k < 2; k++)
        begin
            apb(1, ADCSB_CTRL_OFF, (k ? 15 : 2) << 2);
            apb(1, ADCSB_STAT_OFF, 32'h3);
            seqs(k ? 15 : 2);
            rd(ADCSB_SMP_OFF, k ? 15 : 2);
            chk("irq early", 0, irq);
            seqs(1);
            chk("irq", 1, irq);
            apb(1, ADCSB_MASK_OFF, 32'h0);
            chk("irq masked", 0, irq);
            apb(1, ADCSB_MASK_OFF, 32'h1);
            apb(1, ADCSB_STAT_OFF, 32'h3);
            rd(ADCSB_STAT_OFF, 32'h0);
            chk("irq cleared", 0, irq);
        end
        $display("interrupt done");
        apb(1, ADCSB_CTRL_OFF, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            seqs(1);
            chk("half", i % 2, last.addr[3]);
            rd(ADCSB_CTRL_OFF, 32'h2 | (((i + 1) % 2) << 7));
        end
        rd(ADCSB_STAT_OFF, 32'h3);
        $display("split done");
        for (int m = 0; m < 3; m++)
        begin
            apb(1, ADCSB_CTRL_OFF, m == 0 ? 32'h0401 : (m == 1 ? 32'h0400 : 32'h0));
            s1 = scans;
            seqs(4);
            chk("selector", m == 0 ? 4'h5 : 4'h0, sel_hist);
            chk("scan", m == 0 ? 2 : (m == 1 ? 4 : 0), scans - s1);
            chk("addr", 0, last.addr);
        end
        $display("selector done");
        report_and_stop;
    end
endmodule
